/* pkg/sst_if.sv */
`timescale 1ns/1ps
interface sst_if;
	logic sclk;
	logic sdo;
	logic sdo_oe;

	modport dev (
		input sclk,
		output sdo,
		output sdo_oe
	);

	modport host (
		output sclk,
		input sdo,
		input sdo_oe
	);
endinterface

/* pkg/sst_pkg.sv */
// Operation
// - Single mode end interrupt, continuous buffer-empty interrupt
// - Source select 1 buffer-empty, 0 transfer end
// - Clock select 1 picks second prescaler
// - Only overrun error is detected
// - Words of 7 or 8 bits
// - Serial clock sampled, at most operation clock/6
// - Data phase 1 outputs half cycle earlier
// - Clock phase 1 inverts serial clock
// - MSB or LSB first by configuration
// - Write while buffer full overwrites pending word
// - Change source select before last bit
// - After unit reset, reinitialise, never resume
// - Software sets only own output level bit
// - Software enables own data output pin
// - Start by writing 1 to start bit
package sst_pkg;

	localparam logic [7:0] SST_MODE_OFS = 8'h00;
	localparam logic [7:0] SST_COMM_OFS = 8'h04;
	localparam logic [7:0] SST_DATA_OFS = 8'h08;
	localparam logic [7:0] SST_STAT_OFS = 8'h0c;
	localparam logic [7:0] SST_LEVEL_OFS = 8'h10;
	localparam logic [7:0] SST_OE_OFS = 8'h14;
	localparam logic [7:0] SST_START_OFS = 8'h18;
	localparam logic [7:0] SST_ISTAT_OFS = 8'h1c;
	localparam logic [7:0] SST_IMASK_OFS = 8'h20;

	// Mode register fields
	localparam int SST_MODE_ISRC_BIT = 0;
	localparam int SST_MODE_CKSEL_BIT = 1;
	// Communication setting fields
	localparam int SST_COMM_DAP_BIT = 0;
	localparam int SST_COMM_CKP_BIT = 1;
	localparam int SST_COMM_LSB_BIT = 2;
	localparam int SST_COMM_LEN8_BIT = 3;
	// Status fields
	localparam int SST_STAT_BFF_BIT = 0;
	localparam int SST_STAT_ACT_BIT = 1;
	localparam int SST_STAT_OVF_BIT = 2;
	// Start register fields
	localparam int SST_START_GO_BIT = 0;
	localparam int SST_START_HALT_BIT = 1;
	// Interrupt status fields
	localparam int SST_IRQ_CHAN_BIT = 0;
	localparam int SST_IRQ_OVF_BIT = 1;

	localparam logic [1:0] SST_MODE_RESET = 2'h0;
	localparam logic [3:0] SST_COMM_RESET = 4'h8;
	localparam logic SST_LEVEL_RESET = 1'b1;
	localparam logic [1:0] SST_IMASK_RESET = 2'h0;

	// Prescaler outputs as divisions of hclk
	localparam logic [1:0] SST_PRESC_A_LAST = 2'h1;
	localparam logic [1:0] SST_PRESC_B_LAST = 2'h3;

	// Host serial clock: exactly 6 slowest operation clocks (24 hclk) per period, no margin
	localparam int SST_HCLK_MHZ = 25;
	localparam int SST_SCLK_KHZ = 1000;
	localparam logic [7:0] SST_HALF_CYCLES =
		8'((SST_HCLK_MHZ * 1000) / (2 * SST_SCLK_KHZ) - 1);

endpackage

/* tb/sst_asserts.sv */
`timescale 1ns/1ps
module sst_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdo_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic sclk_q_reg;
	logic [3:0] gap_reg;

	// Saturates so that long idle gaps stay legal
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_q_reg <= 1'b1;
			gap_reg <= 4'hf;
		end else begin
			sclk_q_reg <= sclk;
			if (sclk != sclk_q_reg)
				gap_reg <= 4'h0;
			else if (gap_reg != 4'hf)
				gap_reg <= gap_reg + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_sclk_gap;
		(sclk != sclk_q_reg) |-> gap_reg >= 4'h5;
	endproperty
	a_sclk_gap: assert property (p_sclk_gap)
		else $error("serial clock edges too close");

	property p_sclk_high;
		$rose(sclk) |=> sclk [*5];
	endproperty
	a_sclk_high: assert property (p_sclk_high)
		else $error("serial clock high phase too short");

	property p_sclk_low;
		$fell(sclk) |=> !sclk [*5];
	endproperty
	a_sclk_low: assert property (p_sclk_low)
		else $error("serial clock low phase too short");

	property p_sdo_hold_rise;
		$rose(sclk) |-> $stable(sdo) ##1 $stable(sdo);
	endproperty
	a_sdo_hold_rise: assert property (p_sdo_hold_rise)
		else $error("data moved at rising serial clock");

	property p_sdo_hold_fell;
		$fell(sclk) |=> $stable(sdo);
	endproperty
	a_sdo_hold_fell: assert property (p_sdo_hold_fell)
		else $error("data moved at falling serial clock");

	property p_sdo_setup;
		(sclk != sclk_q_reg) |-> $past(sdo, 3) == sdo;
	endproperty
	a_sdo_setup: assert property (p_sdo_setup)
		else $error("data not settled before serial clock edge");

	property p_oe_frame;
		(sclk != sclk_q_reg) |-> $stable(sdo_oe) ##1 $stable(sdo_oe);
	endproperty
	a_oe_frame: assert property (p_oe_frame)
		else $error("output enable moved during frame");

	property p_sdo_no_glitch;
		$changed(sdo) |=> $stable(sdo);
	endproperty
	a_sdo_no_glitch: assert property (p_sdo_no_glitch)
		else $error("data output toggled on consecutive cycles");
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic start = 1'b0;
	logic dap = 1'b0;
	logic ckp = 1'b0;
	logic lsb = 1'b0;
	logic len8 = 1'b1;
	logic busy;
	logic rx_valid;
	logic [7:0] rx_data;
	logic sclk_q = 1'b1;
	logic bits[$];
	int num_errors = 0;
	int num_checks = 0;

	sst_if link();
	sst_slave_tx sst_slave_tx_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(link));
	sst_spi_host sst_spi_host_i (.hclk(hclk), .hresetn(hresetn), .start(start), .dap(dap),
		.ckp(ckp), .lsb_first(lsb), .len8(len8), .busy(busy), .rx_data(rx_data),
		.rx_valid(rx_valid), .link(link));
	sst_asserts sst_asserts_i (.hclk(hclk), .hresetn(hresetn), .sclk(link.sclk),
		.sdo(link.sdo), .sdo_oe(link.sdo_oe));

	always #20 hclk = ~hclk;

	// Wire monitor: bits taken at the sampling edge of the effective clock
	always @(posedge hclk) begin
		if (link.sclk !== sclk_q && (link.sclk ^ ckp) === !dap)
			bits.push_back(link.sdo);
		sclk_q <= link.sclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task conclude;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task tmo;
		chk("wait_done", 32'h1, 32'h0);
		conclude();
	endtask

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		rd = hrdata;
		if (n >= 100)
			tmo();
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(what, e, r & m);
	endtask

	task host_word;
		int n;
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
		n = 0;
		do begin @(posedge hclk); n++; end while (rx_valid !== 1'b1 && n < 3000);
		if (n >= 3000)
			tmo();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] d;
		logic isrc;
		int len;
		void'($urandom(25170));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("mode_rst", sst_pkg::SST_MODE_OFS, 32'hffffffff, 32'h0);
		rchk("comm_rst", sst_pkg::SST_COMM_OFS, 32'hffffffff, 32'h8);
		rchk("level_rst", sst_pkg::SST_LEVEL_OFS, 32'hffffffff, 32'h1);
		rchk("imask_rst", sst_pkg::SST_IMASK_OFS, 32'hffffffff, 32'h0);
		rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
		// Every data phase, polarity, order and length setting
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom);
			isrc = ^i[3:0];
			len = i[3] ? 8 : 7;
			wr(sst_pkg::SST_START_OFS, 32'h2);
			wr(sst_pkg::SST_MODE_OFS, {30'h0, 1'($urandom), isrc});
			wr(sst_pkg::SST_COMM_OFS, 32'(i));
			dap <= i[0];
			ckp <= i[1];
			lsb <= i[2];
			len8 <= i[3];
			// Idle clock level follows polarity, so let it settle first
			repeat (20) @(posedge hclk);
			bits.delete();
			wr(sst_pkg::SST_IMASK_OFS, 32'h1);
			wr(sst_pkg::SST_OE_OFS, 32'h1);
			wr(sst_pkg::SST_DATA_OFS, 32'($urandom));
			wr(sst_pkg::SST_DATA_OFS, {24'h0, d});
			rchk("buf_full", sst_pkg::SST_STAT_OFS, 32'h1, 32'h1);
			rchk("buf_data", sst_pkg::SST_DATA_OFS, 32'hff, {24'h0, d});
			wr(sst_pkg::SST_START_OFS, 32'h1);
			repeat (4) @(posedge hclk);
			chk("irq_load", {31'h0, isrc}, {31'h0, irq});
			rchk("istat_load", sst_pkg::SST_ISTAT_OFS, 32'h3, {31'h0, isrc});
			rchk("buf_empty", sst_pkg::SST_STAT_OFS, 32'h1, 32'h0);
			rchk("shifting", sst_pkg::SST_STAT_OFS, 32'h2, 32'h2);
			host_word();
			chk("rx_word", {24'h0, d & (i[3] ? 8'hff : 8'h7f)}, {24'h0, rx_data});
			repeat (10) @(posedge hclk);
			rchk("istat_end", sst_pkg::SST_ISTAT_OFS, 32'h3, {31'h0, !isrc});
			chk("bit_count", 32'(len), 32'(bits.size()));
			for (int k = 0; k < len && k < bits.size(); k++)
				chk("wire_bit", {31'h0, lsb ? d[k] : d[len - 1 - k]}, {31'h0, bits[k]});
		end
		wr(sst_pkg::SST_START_OFS, 32'h2);
		wr(sst_pkg::SST_MODE_OFS, 32'h0);
		wr(sst_pkg::SST_COMM_OFS, 32'h8);
		dap <= 1'b0;
		ckp <= 1'b0;
		lsb <= 1'b0;
		len8 <= 1'b1;
		repeat (20) @(posedge hclk);
		wr(sst_pkg::SST_IMASK_OFS, 32'h0);
		wr(sst_pkg::SST_START_OFS, 32'h1);
		repeat (4) @(posedge hclk);
		host_word();
		repeat (10) @(posedge hclk);
		chk("irq_masked", 32'h0, {31'h0, irq});
		rchk("overrun", sst_pkg::SST_STAT_OFS, 32'h4, 32'h4);
		wr(sst_pkg::SST_IMASK_OFS, 32'h2);
		repeat (3) @(posedge hclk);
		chk("irq_ovf", 32'h1, {31'h0, irq});
		rchk("istat_ovf", sst_pkg::SST_ISTAT_OFS, 32'h2, 32'h2);
		repeat (3) @(posedge hclk);
		chk("irq_clr", 32'h0, {31'h0, irq});
		wr(sst_pkg::SST_STAT_OFS, 32'h4);
		rchk("ovf_clr", sst_pkg::SST_STAT_OFS, 32'h4, 32'h0);
		wr(sst_pkg::SST_START_OFS, 32'h2);
		wr(sst_pkg::SST_LEVEL_OFS, 32'h0);
		repeat (3) @(posedge hclk);
		chk("sdo_low", 32'h0, {31'h0, link.sdo});
		wr(sst_pkg::SST_LEVEL_OFS, 32'h1);
		repeat (3) @(posedge hclk);
		chk("sdo_high", 32'h1, {31'h0, link.sdo});
		chk("sdo_oe", 32'h1, {31'h0, link.sdo_oe});
		conclude();
	end
endmodule

/* verilog/sst_slave_tx.sv */
`timescale 1ns/1ps
module sst_slave_tx (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	sst_if.dev link
);

	logic ap_valid, wr_pend_reg, rd_clr;
	logic [7:0] wr_addr_reg, buf_reg, sh_reg, sh_next;
	logic [31:0] hrdata_reg, rd_word;
	logic [1:0] mode_reg, istat_reg, imask_reg, presc_reg;
	logic [3:0] comm_reg, cnt_reg;
	logic level_reg, oe_reg, run_reg, bff_reg, ovf_reg, irq_reg;
	logic op_tick, sck_s1_reg, sck_s2_reg, sck_smp_reg, sck_eff;
	logic rise, fall, shift_edge, sample_edge;
	logic act_reg, primed_reg, last_reg, so_reg;
	logic load, last_sample, ev_end, ev_empty, ev_chan, ev_ovf;
	logic dap, lsb, len8;

	function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = pend && (a == ofs);
	endfunction

	function automatic logic pick_bit(input logic [7:0] s, input logic lsb_f, input logic l8);
		if (lsb_f) begin
			pick_bit = s[0];
		end else begin
			pick_bit = l8 ? s[7] : s[6];
		end
	endfunction

	assign dap = comm_reg[sst_pkg::SST_COMM_DAP_BIT];
	assign lsb = comm_reg[sst_pkg::SST_COMM_LSB_BIT];
	assign len8 = comm_reg[sst_pkg::SST_COMM_LEN8_BIT];

	////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, writes land in the data phase

	assign ap_valid = hsel && htrans[1] && hready;
	assign rd_clr = ap_valid && !hwrite && (haddr[7:0] == sst_pkg::SST_ISTAT_OFS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= ap_valid && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr[7:0])
			sst_pkg::SST_MODE_OFS: rd_word = {30'h0, mode_reg};
			sst_pkg::SST_COMM_OFS: rd_word = {28'h0, comm_reg};
			sst_pkg::SST_DATA_OFS: rd_word = {24'h0, buf_reg};
			sst_pkg::SST_STAT_OFS: rd_word = {29'h0, ovf_reg, act_reg, bff_reg};
			sst_pkg::SST_LEVEL_OFS: rd_word = {31'h0, level_reg};
			sst_pkg::SST_OE_OFS: rd_word = {31'h0, oe_reg};
			sst_pkg::SST_ISTAT_OFS: rd_word = {30'h0, istat_reg};
			sst_pkg::SST_IMASK_OFS: rd_word = {30'h0, imask_reg};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else begin
			hrdata_reg <= (ap_valid && !hwrite) ? rd_word : 32'h0000_0000;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= sst_pkg::SST_MODE_RESET;
			comm_reg <= sst_pkg::SST_COMM_RESET;
			level_reg <= sst_pkg::SST_LEVEL_RESET;
			oe_reg <= 1'b0;
			imask_reg <= sst_pkg::SST_IMASK_RESET;
		end else begin
			// Source select may change mid-run; software owns the timing
			if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_MODE_OFS)) begin
				mode_reg <= hwdata[1:0];
			end
			if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_COMM_OFS)) begin
				comm_reg <= hwdata[3:0];
			end
			if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_LEVEL_OFS)) begin
				level_reg <= hwdata[0];
			end
			if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_OE_OFS)) begin
				oe_reg <= hwdata[0];
			end
			if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_IMASK_OFS)) begin
				imask_reg <= hwdata[1:0];
			end
		end
	end

	// Stop also drops the transmit buffer, so a restart needs fresh setup
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_reg <= 1'b0;
		end else if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_START_OFS)) begin
			if (hwdata[sst_pkg::SST_START_HALT_BIT]) begin
				run_reg <= 1'b0;
			end else if (hwdata[sst_pkg::SST_START_GO_BIT]) begin
				run_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_reg <= 8'h00;
			bff_reg <= 1'b0;
		end else if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_START_OFS) &&
			hwdata[sst_pkg::SST_START_HALT_BIT]) begin
			bff_reg <= 1'b0;
		end else if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_DATA_OFS)) begin
			buf_reg <= hwdata[7:0];
			bff_reg <= 1'b1;
		end else if (load) begin
			bff_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operation clock and serial clock sampling

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_reg <= 2'h0;
		end else begin
			presc_reg <= presc_reg + 2'h1;
		end
	end

	assign op_tick = mode_reg[sst_pkg::SST_MODE_CKSEL_BIT] ?
		(presc_reg == sst_pkg::SST_PRESC_B_LAST) :
		(presc_reg[0] == sst_pkg::SST_PRESC_A_LAST[0]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_s1_reg <= 1'b1;
			sck_s2_reg <= 1'b1;
		end else begin
			sck_s1_reg <= link.sclk;
			sck_s2_reg <= sck_s1_reg;
		end
	end

	assign sck_eff = sck_s2_reg ^ comm_reg[sst_pkg::SST_COMM_CKP_BIT];

	// Sampling only on the operation tick limits the usable rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_smp_reg <= 1'b1;
		end else if (op_tick) begin
			sck_smp_reg <= sck_eff;
		end
	end

	assign rise = op_tick && !sck_smp_reg && sck_eff;
	assign fall = op_tick && sck_smp_reg && !sck_eff;
	assign shift_edge = dap ? rise : fall;
	assign sample_edge = dap ? fall : rise;

	////////////////////////////////////////////////////////////////////////
	// Shift engine

	assign load = run_reg && !act_reg && bff_reg;
	assign last_sample = sample_edge && (cnt_reg == (len8 ? 4'h7 : 4'h6));
	assign sh_next = lsb ? {1'b0, sh_reg[7:1]} : {sh_reg[6:0], 1'b0};
	assign ev_end = act_reg && ((last_sample && !dap) || (shift_edge && last_reg));
	assign ev_empty = load;
	assign ev_chan = mode_reg[sst_pkg::SST_MODE_ISRC_BIT] ? ev_empty : ev_end;
	assign ev_ovf = run_reg && !act_reg && !load && sample_edge;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_reg <= 8'h00;
			act_reg <= 1'b0;
			cnt_reg <= 4'h0;
			primed_reg <= 1'b0;
			last_reg <= 1'b0;
			so_reg <= sst_pkg::SST_LEVEL_RESET;
		end else if (!run_reg) begin
			act_reg <= 1'b0;
			so_reg <= level_reg;
		end else if (load) begin
			sh_reg <= buf_reg;
			act_reg <= 1'b1;
			cnt_reg <= 4'h0;
			last_reg <= 1'b0;
			primed_reg <= dap;
			if (dap) begin
				so_reg <= pick_bit(buf_reg, lsb, len8);
			end
		end else if (act_reg) begin
			if (ev_end) begin
				act_reg <= 1'b0;
			end else if (shift_edge) begin
				if (!primed_reg) begin
					so_reg <= pick_bit(sh_reg, lsb, len8);
					primed_reg <= 1'b1;
				end else begin
					sh_reg <= sh_next;
					so_reg <= pick_bit(sh_next, lsb, len8);
				end
			end
			if (sample_edge) begin
				cnt_reg <= cnt_reg + 4'h1;
				if (last_sample) begin
					last_reg <= 1'b1;
				end
			end
		end
	end

	assign link.sdo = so_reg;
	assign link.sdo_oe = oe_reg;

	////////////////////////////////////////////////////////////////////////
	// Error flag and interrupt

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_reg <= 1'b0;
		end else if (ev_ovf) begin
			ovf_reg <= 1'b1;
		end else if (wr_hit(wr_pend_reg, wr_addr_reg, sst_pkg::SST_STAT_OFS) &&
			hwdata[sst_pkg::SST_STAT_OVF_BIT]) begin
			ovf_reg <= 1'b0;
		end
	end

	// Set beats the read-clear, so no event is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			istat_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			istat_reg <= (rd_clr ? 2'h0 : istat_reg) | {ev_ovf, ev_chan};
			irq_reg <= |(((rd_clr ? 2'h0 : istat_reg) | {ev_ovf, ev_chan}) & imask_reg);
		end
	end

	assign irq = irq_reg;

endmodule

/* verilog/sst_spi_host.sv */
`timescale 1ns/1ps
module sst_spi_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic dap,
	input wire logic ckp,
	input wire logic lsb_first,
	input wire logic len8,
	output logic busy,
	output logic [7:0] rx_data,
	output logic rx_valid,
	sst_if.host link
);

	typedef enum logic {SST_H_IDLE, SST_H_RUN} sst_hstate_t;

	sst_hstate_t state_reg;
	logic [7:0] hc_reg;
	logic [4:0] ec_reg;
	logic sclk_reg;
	logic [7:0] rx_reg;
	logic [7:0] rx_next;
	logic [7:0] rx_data_reg;
	logic rx_valid_reg;
	logic dap_l_reg;
	logic ckp_l_reg;
	logic lsb_l_reg;
	logic len8_l_reg;
	logic edge_now;
	logic samp_now;
	logic last_edge;

	assign edge_now = (state_reg == SST_H_RUN) && (hc_reg == sst_pkg::SST_HALF_CYCLES);
	// Even edges fall, odd edges rise on the uninverted clock
	assign samp_now = edge_now && (ec_reg[0] != dap_l_reg);
	assign last_edge = edge_now && (ec_reg == (len8_l_reg ? 5'd15 : 5'd13));

	always_comb begin
		rx_next = rx_reg;
		if (samp_now) begin
			rx_next = lsb_l_reg ? {link.sdo, rx_reg[7:1]} : {rx_reg[6:0], link.sdo};
		end
	end

	// Half period fixed so the device sees six of the slowest operation clocks per bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= SST_H_IDLE;
			hc_reg <= 8'h00;
			ec_reg <= 5'd0;
			sclk_reg <= 1'b1;
			rx_reg <= 8'h00;
			rx_data_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			dap_l_reg <= 1'b0;
			ckp_l_reg <= 1'b0;
			lsb_l_reg <= 1'b0;
			len8_l_reg <= 1'b1;
		end else begin
			rx_valid_reg <= 1'b0;
			case (state_reg)
				SST_H_IDLE: begin
					sclk_reg <= ~ckp;
					if (start) begin
						state_reg <= SST_H_RUN;
						hc_reg <= 8'h00;
						ec_reg <= 5'd0;
						rx_reg <= 8'h00;
						dap_l_reg <= dap;
						ckp_l_reg <= ckp;
						lsb_l_reg <= lsb_first;
						len8_l_reg <= len8;
					end
				end
				SST_H_RUN: begin
					rx_reg <= rx_next;
					if (edge_now) begin
						hc_reg <= 8'h00;
						ec_reg <= ec_reg + 5'd1;
						sclk_reg <= ~sclk_reg;
					end else begin
						hc_reg <= hc_reg + 8'h01;
					end
					if (last_edge) begin
						state_reg <= SST_H_IDLE;
						rx_valid_reg <= 1'b1;
						rx_data_reg <= (lsb_l_reg && !len8_l_reg) ? {1'b0, rx_next[7:1]} : rx_next;
					end
				end
				default: state_reg <= SST_H_IDLE;
			endcase
		end
	end

	assign link.sclk = sclk_reg;
	assign busy = (state_reg == SST_H_RUN);
	assign rx_data = rx_data_reg;
	assign rx_valid = rx_valid_reg;

endmodule
